// [core/mmcb_top.v]
// How it works
// - Bank 0 always at 0x0000-0x7FFF
// - Fetch field picks upper fetch bank
// - Constant field picks upper code-move/flash bank
// - Fetch field writable only from bank 0
// - PC-relative code-move uses constant field
// - Reserved select bits read zero
// - Bank select resets to 0x11
// - Top flash byte is lock byte
// - Code-move reads flash; external-move RAM or flash
// - 256 bytes internal RAM, low half both modes
// - Above 0x7f: direct registers, indirect RAM
// - Four register banks, status bits 3-4 select
// - Bank n occupies 8n to 8n+7
// - Indirect pointer from working reg 0/1
// - Bit space maps onto 0x20-0x2f
// - Operand type chooses bit or byte access
// - Push writes stack_pointer+1, then increments
// - Stack pointer resets to 0x07
// - Stack anywhere in 256 bytes
// - External RAM via pointer or high byte
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_defs.vh"
module mmcb_top #(
    parameter ONCHIP_EXTERNAL_RAM_BYTES = `MMCB_ONCHIP_EXTERNAL_RAM_BYTES,
    parameter ONCHIP_EXTERNAL_RAM_AW = 13
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Core access request
    input wire req,
    input wire [2:0] kind,
    input wire [15:0] addr,
    input wire [15:0] pc,
    input wire pc_rel,
    input wire use_ptr,
    input wire ptr_sel,
    input wire [15:0] data_pointer,
    input wire wr,
    input wire [7:0] wdata,
    input wire flash_write_en,
    // Code side results
    output reg [16:0] flash_addr,
    output reg flash_rd,
    output reg flash_wr,
    output reg lock_hit,
    // Data side results
    output reg [7:0] rdata,
    output reg sfr_hit,
    output reg [7:0] sfr_addr,
    output reg onchip_external_ram_err,
    // Register views
    output reg [7:0] program_bank_select,
    output reg [7:0] stack_pointer,
    output reg [1:0] active_bank
);
    // Internal RAM, upper half only by indirect or stack
    reg [7:0] iram [0:255];
    // On-chip external RAM
    reg [7:0] onchip_external_ram [0:ONCHIP_EXTERNAL_RAM_BYTES-1];
    // Writable state
    reg [1:0] fetch_bank_sel_r;
    reg [1:0] constant_bank_sel_r;
    // Pointer to the last used stack location
    reg [7:0] stack_pointer_r;
    // Status word, only the bank bits matter here
    reg [7:0] program_status_word_r;
    // High address byte for 8-bit external moves
    reg [7:0] onchip_external_ram_high_byte_ctrl_r;
    // Bank register read value, reserved bits zero
    wire [7:0] bank_rd = {2'h0, constant_bank_sel_r, 2'h0,
        fetch_bank_sel_r};
    // Active register bank from the status word
    wire [1:0] rbank = program_status_word_r[`MMCB_RS_HI:`MMCB_RS_LO];
    // Where the writing instruction lives: the lower half is always
    // bank 0, and the upper half is bank 0 too while the fetch field
    // is zero; checking pc[15] alone would lock out legal bank 0 code
    wire pc_low_half = ~pc[`MMCB_UPPER_BIT];
    // Upper half running with the fetch field at zero
    wire pc_upper_bank0 = (fetch_bank_sel_r == 2'h0);
    wire pc_in_bank0 = pc_low_half | pc_upper_bank0;
    // Code-side bank choice
    wire is_fetch = (kind == `MMCB_K_FETCH);
    wire [1:0] code_bank = is_fetch ? fetch_bank_sel_r
        : constant_bank_sel_r;
    // PC-relative code move offsets pc but keeps the constant bank
    // Sum kept 17 bits wide; the carry is dropped on purpose since
    // the logical code space wraps at 64 kB
    wire [16:0] rel_sum = pc + addr;
    // Code-move with pc_rel uses the sum, everything else the address
    wire use_rel = (kind == `MMCB_K_CMOVE) && pc_rel;
    wire [15:0] code_addr = use_rel ? rel_sum[15:0] : addr;
    // Physical flash address and lock flag from the code map
    wire [16:0] phys;
    wire lock_w;
    mmcb_code_map u_code (
        .addr(code_addr),
        .bank(code_bank),
        .phys(phys),
        .lock_hit(lock_w),
        .reserved()
    );
    // Indirect pointer from working reg 0/1 of active bank
    wire [7:0] ptr_loc = {3'h0, rbank, 2'h0, ptr_sel};
    wire [7:0] ptr_val = iram[ptr_loc];
    wire indirect = (kind == `MMCB_K_INDIRECT);
    wire [7:0] dm_in = (indirect && use_ptr) ? ptr_val : addr[7:0];
    // Decoded RAM address, bit position and register-space flag
    wire [7:0] ram_a;
    wire [2:0] bpos;
    wire to_sfr;
    mmcb_data_map u_data (
        .addr(dm_in),
        .direct(kind == `MMCB_K_DIRECT || kind == `MMCB_K_BIT),
        .is_bit(kind == `MMCB_K_BIT),
        .ram_addr(ram_a),
        .bit_pos(bpos),
        .to_sfr(to_sfr)
    );
    // External address: full pointer, or high byte plus reg 0/1
    wire [15:0] xaddr = use_ptr ? {onchip_external_ram_high_byte_ctrl_r, ptr_val}
        : data_pointer;
    // Index into the on-chip RAM
    wire [ONCHIP_EXTERNAL_RAM_AW-1:0] xidx = xaddr[ONCHIP_EXTERNAL_RAM_AW-1:0];
    // Addresses past the on-chip RAM are flagged, not aliased
    wire xin = (xaddr < ONCHIP_EXTERNAL_RAM_BYTES);
    // Register space hits for this block's own registers
    // Indirect accesses never hit, since to_sfr needs direct mode
    // Bank select register
    wire hit_bank = to_sfr && ram_a == `MMCB_BANK_SEL_ADDR;
    wire hit_sp = to_sfr && ram_a == `MMCB_SP_ADDR;
    wire hit_psw = to_sfr && ram_a == `MMCB_PSW_ADDR;
    wire hit_xhi = to_sfr && ram_a == `MMCB_XHI_ADDR;
    // Stack addresses: pre-increment push, post-decrement pop
    // Eight bits wide, so a full stack wraps to 0x00
    wire [7:0] sp_inc = stack_pointer_r + 8'h01;
    // Register updates
    // Both bank fields come up on bank 1, which is harmless on parts
    // with a single upper bank
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Bank select fields, 0x11 as a whole
            fetch_bank_sel_r <= 2'h1;
            constant_bank_sel_r <= 2'h1;
            stack_pointer_r <= `MMCB_SP_RST;
            program_status_word_r <= `MMCB_PSW_RST;
            onchip_external_ram_high_byte_ctrl_r <= `MMCB_XHI_RST;
        end else if (req) begin
            // Stack moves come first; a push or pop never also writes
            // a register through the direct path in the same cycle
            if (kind == `MMCB_K_PUSH) begin
                // Wraps through all 256 bytes
                stack_pointer_r <= sp_inc;
            end else if (kind == `MMCB_K_POP) begin
                // Pop reads at the pointer, then steps it back
                stack_pointer_r <= stack_pointer_r - 8'h01;
            end else if (kind == `MMCB_K_DIRECT && wr) begin
                // Only direct writes reach these registers; indirect
                // writes above 0x7f land in upper RAM instead
                if (hit_bank) begin
                    // Constant field is free to change from any bank
                    constant_bank_sel_r <=
                        wdata[`MMCB_CONST_HI:`MMCB_CONST_LO];
                    // Ignored unless code runs from bank 0
                    if (pc_in_bank0)
                        fetch_bank_sel_r <=
                            wdata[`MMCB_FETCH_HI:`MMCB_FETCH_LO];
                end
                // Stack pointer may be placed anywhere
                if (hit_sp)
                    stack_pointer_r <= wdata;
                // Status word carries the register bank bits
                if (hit_psw)
                    program_status_word_r <= wdata;
                // High address byte for 8-bit external moves
                if (hit_xhi)
                    onchip_external_ram_high_byte_ctrl_r <= wdata;
            end
        end
    end
    // Memory writes, no reset on arrays
    // RAM contents are undefined after power-up, as software expects;
    // resetting 8 kB of flops would cost far more than it gives
    always @(posedge clock) begin
        if (req && wr) begin
            case (kind)
                // Byte writes to RAM; register writes handled above
                `MMCB_K_DIRECT, `MMCB_K_INDIRECT: begin
                    if (!to_sfr)
                        iram[ram_a] <= wdata;
                end
                `MMCB_K_BIT: begin
                    // Bit addresses 0x80 and up are register bits, not
                    // RAM; without this guard they would corrupt the
                    // low bit bytes through the folded byte address
                    if (!to_sfr)
                        iram[ram_a] <= (iram[ram_a] & ~(8'h01 << bpos))
                            | ({7'h00, wdata[0]} << bpos);
                end
                // Push lands one above the pointer
                `MMCB_K_PUSH: iram[sp_inc] <= wdata;
                // External move: on-chip RAM unless steered to flash
                `MMCB_K_XMOVE: begin
                    // Flash mode steers writes away from RAM
                    if (!flash_write_en && xin)
                        onchip_external_ram[xidx] <= wdata;
                end
                // Fetch, code move and pop write nothing
                default: ;
            endcase
        end
    end
    // Registered outputs
    // Every result leaves a flop one cycle after the request, so the
    // core sees a fixed one-cycle answer whatever the access kind
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Pulses low, held values cleared
            flash_addr <= 17'h00000;
            flash_rd <= 1'b0;
            flash_wr <= 1'b0;
            lock_hit <= 1'b0;
            rdata <= 8'h00;
            sfr_hit <= 1'b0;
            sfr_addr <= 8'h00;
            onchip_external_ram_err <= 1'b0;
        end else begin
            // Flash is read by fetches and code moves only
            flash_rd <= req && (is_fetch || kind == `MMCB_K_CMOVE);
            // External moves write flash only when steered there
            flash_wr <= req && kind == `MMCB_K_XMOVE && wr
                && flash_write_en;
            // Lock byte touched by a data-style access; fetches of it
            // are ordinary code and not flagged
            lock_hit <= req && lock_w && !is_fetch;
            // Direct and bit accesses above 0x7f go to registers
            sfr_hit <= req && to_sfr && (kind == `MMCB_K_DIRECT
                || kind == `MMCB_K_BIT);
            // Address follows the decoder every cycle; only valid
            // alongside sfr_hit
            sfr_addr <= ram_a;
            // RAM-directed external move past the on-chip RAM
            onchip_external_ram_err <= req && kind == `MMCB_K_XMOVE && !flash_write_en
                && !xin;
            // Flash address holds until the next code-side access so
            // the core can read it at leisure
            if (req && (is_fetch || kind == `MMCB_K_CMOVE
                || (kind == `MMCB_K_XMOVE && flash_write_en)))
                flash_addr <= phys;
            // Read data likewise holds until the next data access other than a push
            if (req) begin
                case (kind)
                    // Byte accesses: own registers, other registers, RAM
                    `MMCB_K_DIRECT, `MMCB_K_INDIRECT: begin
                        if (hit_bank)
                            rdata <= bank_rd;
                        else if (hit_sp)
                            rdata <= stack_pointer_r;
                        else if (hit_psw)
                            rdata <= program_status_word_r;
                        else if (hit_xhi)
                            rdata <= onchip_external_ram_high_byte_ctrl_r;
                        else if (to_sfr)
                            // Registers outside this block read zero
                            rdata <= 8'h00;
                        else
                            // Low RAM, or upper RAM by indirect access
                            rdata <= iram[ram_a];
                    end
                    // Single bit, right-aligned
                    `MMCB_K_BIT: rdata <= {7'h00, iram[ram_a][bpos]};
                    // Pop returns the last used location
                    `MMCB_K_POP: rdata <= iram[stack_pointer_r];
                    // Beyond the on-chip RAM reads zero
                    `MMCB_K_XMOVE: rdata <= xin ? onchip_external_ram[xidx] : 8'h00;
                    // Fetch, code move and push leave the data held
                    default: rdata <= rdata;
                endcase
            end
        end
    end
    // Register views straight from flops
    // They trail the live registers by one cycle; a check right after
    // a write must wait one more edge before looking
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            program_bank_select <= `MMCB_BANK_SEL_RST;
            stack_pointer <= `MMCB_SP_RST;
            active_bank <= 2'h0;
        end else begin
            program_bank_select <= bank_rd;
            stack_pointer <= stack_pointer_r;
            active_bank <= rbank;
        end
    end
endmodule // mmcb_top
`default_nettype wire

// [include/mmcb_defs.vh]
`ifndef MMCB_DEFS_VH
`define MMCB_DEFS_VH
// Special function register addresses
`define MMCB_BANK_SEL_ADDR 8'h84
`define MMCB_PSW_ADDR 8'hd0
`define MMCB_SP_ADDR 8'h81
`define MMCB_XHI_ADDR 8'haa
// Reset values
`define MMCB_BANK_SEL_RST 8'h11
`define MMCB_SP_RST 8'h07
`define MMCB_PSW_RST 8'h00
`define MMCB_XHI_RST 8'h00
// Bank select field positions
`define MMCB_FETCH_HI 1
`define MMCB_FETCH_LO 0
`define MMCB_CONST_HI 5
`define MMCB_CONST_LO 4
// Status word bank bits
`define MMCB_RS_HI 4
`define MMCB_RS_LO 3
// Address boundaries
`define MMCB_UPPER_BIT 15
`define MMCB_LOW_DATA_BIT 7
`define MMCB_BIT_BYTE_BASE 8'h20
`define MMCB_LOCK_ADDR 17'h1ffff
`define MMCB_ONCHIP_EXTERNAL_RAM_BYTES 8192
// Access kinds from the core
`define MMCB_K_FETCH 3'h0
`define MMCB_K_CMOVE 3'h1
`define MMCB_K_XMOVE 3'h2
`define MMCB_K_DIRECT 3'h3
`define MMCB_K_INDIRECT 3'h4
`define MMCB_K_BIT 3'h5
`define MMCB_K_PUSH 3'h6
`define MMCB_K_POP 3'h7
`endif

// [core/mmcb_code_map.v]
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_defs.vh"
// Program address to physical flash address
module mmcb_code_map (
    // Logical address and bank field
    input wire [15:0] addr,
    input wire [1:0] bank,
    // Physical flash address
    output wire [16:0] phys,
    output wire lock_hit,
    output wire reserved
);
    // Lower half always bank 0, upper half uses the field
    wire upper = addr[`MMCB_UPPER_BIT];
    wire [1:0] eff_bank = upper ? bank : 2'h0;
    assign phys = {eff_bank, addr[14:0]};
    // Top byte is the lock byte; nothing above exists here
    assign lock_hit = (phys == `MMCB_LOCK_ADDR);
    assign reserved = 1'b0;
endmodule // mmcb_code_map
`default_nettype wire

// [core/mmcb_data_map.v]
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_defs.vh"
// Internal data address decode
module mmcb_data_map (
    // Access request
    input wire [7:0] addr,
    input wire direct,
    input wire is_bit,
    // Decode results
    output wire [7:0] ram_addr,
    output wire [2:0] bit_pos,
    output wire to_sfr
);
    // Bit addresses land in the 0x20..0x2f window
    wire [7:0] bit_byte = `MMCB_BIT_BYTE_BASE + {4'h0, addr[6:3]};
    assign ram_addr = is_bit ? bit_byte : addr;
    assign bit_pos = addr[2:0];
    // High half: direct goes to registers, indirect to RAM
    assign to_sfr = addr[`MMCB_LOW_DATA_BIT] & direct;
endmodule // mmcb_data_map
`default_nettype wire

// [tb/mmcb_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checker, one clock domain
module mmcb_monitor #(
    parameter ONCHIP_EXTERNAL_RAM_BYTES = 8192
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Core request
    input wire logic req,
    input wire logic [2:0] kind,
    input wire logic [15:0] addr,
    input wire logic [15:0] pc,
    input wire logic pc_rel,
    input wire logic use_ptr,
    input wire logic [15:0] data_pointer,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic flash_write_en,
    // Results
    input wire logic [16:0] flash_addr,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic lock_hit,
    input wire logic sfr_hit,
    input wire logic [7:0] sfr_addr,
    input wire logic onchip_external_ram_err,
    input wire logic [7:0] program_bank_select,
    input wire logic [7:0] stack_pointer,
    input wire logic [1:0] active_bank
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Decoded requests; bank view lags the live field by one cycle
    wire logic fx = req && kind == 3'h0;
    wire logic cm = req && kind == 3'h1 && !pc_rel;
    wire logic dw = req && kind == 3'h3 && wr;
    wire logic [7:0] psb = program_bank_select;
    AST_LOW_FIXED: assert property (fx && !addr[15] |=>
        flash_addr == {2'b00, $past(addr[14:0])}) else $error("low map");
    AST_FETCH_BANK: assert property (fx && addr[15] |=>
        flash_rd && flash_addr == {psb[1:0], $past(addr[14:0])})
        else $error("fetch map");
    AST_CONST_BANK: assert property (cm && addr[15] |=>
        flash_addr == {psb[5:4], $past(addr[14:0])}) else $error("const map");
    AST_FETCH_LOCK: assert property (
        dw && addr[7:0] == 8'h84 && pc[15] |=> ##1 psb[1:0] ==
        ($past(psb[1:0]) == 2'b00 ? $past(wdata[1:0], 2) : $past(psb[1:0]))
        && psb[5:4] == $past(wdata[5:4], 2)) else $error("bank lock");
    AST_RSVD_ZERO: assert property (
        psb[7:6] == 2'b00 && psb[3:2] == 2'b00) else $error("reserved bits");
    AST_RESET_VAL: assert property (
        $rose(rstn) |-> psb == 8'h11 && stack_pointer == 8'h07)
        else $error("reset values");
    AST_SFR_DIRECT: assert property (
        req && kind == 3'h3 && addr[7] |=> sfr_hit &&
        sfr_addr == $past(addr[7:0])) else $error("sfr route");
    AST_PUSH_STEP: assert property (req && kind == 3'h6 |=> ##1
        stack_pointer == 8'($past(stack_pointer) + 8'h01)) else $error("push");
    AST_REG_BANK: assert property (
        dw && addr[7:0] == 8'hd0 |=> ##1 active_bank == $past(wdata[4:3], 2))
        else $error("register bank");
    AST_ONCHIP_EXTERNAL_RAM_RANGE: assert property (
        req && kind == 3'h2 && !use_ptr && !flash_write_en
        |=> onchip_external_ram_err == ($past(data_pointer) >= ONCHIP_EXTERNAL_RAM_BYTES)) else $error("onchip_external_ram");
    AST_FLASH_WR: assert property (
        req && kind == 3'h2 && wr |=> flash_wr == $past(flash_write_en))
        else $error("flash write");
    AST_LOCK_BYTE: assert property (
        req && (kind == 3'h1 || (kind == 3'h2 && flash_write_en))
        |=> lock_hit == (flash_addr == 17'h1ffff)) else $error("lock byte");
    // Main scenarios reached
    cover property (fx && addr[15]);
    cover property (req && kind == 3'h6);
    cover property (onchip_external_ram_err);
    cover property (req && kind == 3'h2 && wr && flash_write_en);
endmodule // mmcb_monitor
bind mmcb_top mmcb_monitor #(.ONCHIP_EXTERNAL_RAM_BYTES(ONCHIP_EXTERNAL_RAM_BYTES)) u_mon (
    .clock(clock), .rstn(rstn), .req(req), .kind(kind), .addr(addr),
    .pc(pc), .pc_rel(pc_rel), .use_ptr(use_ptr), .data_pointer(data_pointer),
    .wr(wr), .wdata(wdata), .flash_write_en(flash_write_en),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .sfr_hit(sfr_hit),
    .flash_wr(flash_wr), .lock_hit(lock_hit),
    .sfr_addr(sfr_addr), .onchip_external_ram_err(onchip_external_ram_err),
    .program_bank_select(program_bank_select),
    .stack_pointer(stack_pointer), .active_bank(active_bank));
`default_nettype wire

// [tb/mmcb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Core side: one access at a time
module mmcb_core_model (
    // Clock
    input wire logic clock,
    // Access request
    output var logic req,
    output var logic [2:0] kind,
    output var logic [15:0] addr,
    output var logic wr,
    output var logic [7:0] wdata
);
    // Idle at time zero
    initial begin
        {req, kind, addr, wr, wdata} = 0;
    end
    // Held for one edge, then released; two edges let the views settle
    task automatic go(input logic [2:0] k, input logic [15:0] a,
            input logic w, input logic [7:0] d);
        req <= 1'b1;
        kind <= k;
        addr <= a;
        wr <= w;
        wdata <= d;
        @(posedge clock);
        req <= 1'b0;
        // Released address and data lines flip so stale values never look valid
        addr <= ~a;
        wdata <= ~d;
        repeat (2) @(posedge clock);
    endtask
endmodule // mmcb_core_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking run of the mapping block
module tb_top;
    // Clock, reset and side inputs
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] pc = 16'h0100;
    logic pc_rel = 1'b0;
    logic use_ptr = 1'b0;
    logic ptr_sel = 1'b0;
    logic [15:0] data_pointer = 16'h0000;
    logic flash_write_en = 1'b0;
    // Core request and results
    wire logic req, wr;
    wire logic [2:0] kind;
    wire logic [15:0] addr;
    wire logic [7:0] wdata, rdata, psb, sp;
    wire logic [16:0] flash_addr;
    wire logic [1:0] active_bank;
    int err_total = 0;
    int tests_run = 0;
    int b;
    mmcb_core_model core (.clock(clock), .req(req), .kind(kind),
        .addr(addr), .wr(wr), .wdata(wdata));
    mmcb_top uut (.clock(clock), .rstn(rstn), .req(req), .kind(kind),
        .addr(addr), .pc(pc), .pc_rel(pc_rel), .use_ptr(use_ptr),
        .ptr_sel(ptr_sel), .data_pointer(data_pointer), .wr(wr),
        .wdata(wdata), .flash_write_en(flash_write_en),
        .flash_addr(flash_addr), .flash_rd(), .flash_wr(), .lock_hit(),
        .rdata(rdata), .sfr_hit(), .sfr_addr(), .onchip_external_ram_err(),
        .program_bank_select(psb), .stack_pointer(sp),
        .active_bank(active_bank));
    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic chk(input string what, input logic [16:0] seen,
            input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic put(input logic [2:0] k, input logic [15:0] a,
            input logic [7:0] d);
        core.go(k, a, 1'b1, d);
    endtask
    task automatic get(input logic [2:0] k, input logic [15:0] a);
        core.go(k, a, 1'b0, 8'h00);
    endtask
    task automatic conclude();
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 160 cycles used
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("bank reset", psb, 17'h11);
        chk("sp reset", sp, 17'h07);
        put(3'h3, 16'h0084, 8'hff);
        get(3'h3, 16'h0084);
        chk("bank read", rdata, 17'h33);
        // Every fetch and constant bank code
        for (b = 0; b < 4; b++) begin
            put(3'h3, 16'h0084, 8'((3 - b) << 4 | b));
            get(3'h0, 16'h8123);
            chk("fetch up", flash_addr, {b[1:0], 15'h0123});
            get(3'h1, 16'h8123);
            chk("const up", flash_addr, {2'(3 - b), 15'h0123});
            get(3'h0, 16'h1234);
            chk("fetch low", flash_addr, 17'h01234);
        end
        // Upper-bank code: relative move, then a refused fetch change
        pc <= 16'h8000;
        pc_rel <= 1'b1;
        get(3'h1, 16'h0010);
        chk("pc rel", flash_addr, 17'h00010);
        pc_rel <= 1'b0;
        put(3'h3, 16'h0084, 8'h32);
        chk("bank lock", psb, 17'h33);
        // Upper code running from bank 0 may still move the fetch field
        pc <= 16'h0100;
        put(3'h3, 16'h0084, 8'h30);
        pc <= 16'h8000;
        put(3'h3, 16'h0084, 8'h32);
        chk("bank0 upper", psb, 17'h32);
        pc <= 16'h0100;
        get(3'h1, 16'hffff);
        chk("lock byte", flash_addr, 17'h1ffff);
        // Upper RAM against registers
        put(3'h4, 16'h0090, 8'ha5);
        put(3'h3, 16'h0090, 8'h11);
        get(3'h4, 16'h0090);
        chk("upper ram", rdata, 17'ha5);
        get(3'h3, 16'h0090);
        chk("sfr read", rdata, 17'h00);
        put(3'h3, 16'h0030, 8'h66);
        get(3'h4, 16'h0030);
        chk("low ram", rdata, 17'h66);
        // Bit 0x13 is bit 3 of byte 0x22
        put(3'h3, 16'h0022, 8'h00);
        put(3'h5, 16'h0013, 8'h01);
        get(3'h3, 16'h0022);
        chk("bit map", rdata, 17'h08);
        put(3'h3, 16'h00d0, 8'h08);
        chk("active bank", active_bank, 17'h1);
        put(3'h3, 16'h0009, 8'h55);
        use_ptr <= 1'b1;
        ptr_sel <= 1'b1;
        put(3'h4, 16'h0000, 8'h77);
        use_ptr <= 1'b0;
        get(3'h3, 16'h0055);
        chk("pointer reg", rdata, 17'h77);
        // External RAM by full pointer and by high byte plus reg 0
        data_pointer <= 16'h1234;
        put(3'h2, 16'h0000, 8'h5a);
        put(3'h3, 16'h00aa, 8'h12);
        put(3'h3, 16'h0008, 8'h34);
        use_ptr <= 1'b1;
        ptr_sel <= 1'b0;
        get(3'h2, 16'h0000);
        chk("onchip_external_ram paged", rdata, 17'h5a);
        use_ptr <= 1'b0;
        data_pointer <= 16'h2000;
        get(3'h2, 16'h0000);
        chk("onchip_external_ram beyond", rdata, 17'h00);
        // Flash-directed move: constant bank, RAM left alone
        flash_write_en <= 1'b1;
        data_pointer <= 16'h1234;
        put(3'h2, 16'h9abc, 8'hee);
        chk("flash move", flash_addr, 17'h19abc);
        flash_write_en <= 1'b0;
        get(3'h2, 16'h0000);
        chk("onchip_external_ram kept", rdata, 17'h5a);
        // Stack: first push, pop, then the top of memory
        put(3'h6, 16'h0000, 8'h3c);
        chk("push sp", sp, 17'h08);
        get(3'h3, 16'h0008);
        chk("push data", rdata, 17'h3c);
        get(3'h7, 16'h0000);
        chk("pop data", rdata, 17'h3c);
        chk("pop sp", sp, 17'h07);
        put(3'h3, 16'h0081, 8'hfe);
        put(3'h6, 16'h0000, 8'hc3);
        get(3'h4, 16'h00ff);
        chk("stack top", rdata, 17'hc3);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
